// ==== wdog_pkg.sv ====
// package for the super i/o watchdog block: port addresses, register indexes, fields, timing
// assumes a host i/o cycle interface delivering one-cycle write/read strobes on clk
package wdog_pkg;

    // ------------------------------------------------------------
    // i/o ports and unlock sequence
    // ------------------------------------------------------------
    localparam logic [7:0] INDEX_PORT      = 8'h2E;
    localparam logic [7:0] DATA_PORT       = 8'h2F;
    localparam logic [7:0] UNLOCK_BYTE     = 8'h87;
    localparam logic [7:0] LOCK_BYTE       = 8'hAA;

    // ------------------------------------------------------------
    // configuration register indexes
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_LDEV_SELECT = 8'h07;
    localparam logic [7:0] IDX_ACTIVATE    = 8'h30;
    localparam logic [7:0] IDX_TIME_UNIT   = 8'hF0;
    localparam logic [7:0] IDX_COUNT_VALUE = 8'hF1;
    localparam logic [7:0] WDOG_LDEV       = 8'h08;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         ACTIVATE_BIT    = 0;
    localparam int         MINUTE_BIT      = 3;
    localparam logic [7:0] RESET_BYTE      = 8'h00;

    // ------------------------------------------------------------
    // timing at 25 MHz
    // ------------------------------------------------------------
    localparam longint     CLK_HZ          = 25000000;
    localparam longint     SECOND_S        = 1;
    localparam longint     SECOND_CYCLES   = CLK_HZ * SECOND_S;
    localparam logic [5:0] SECONDS_PER_MIN = 6'h3C;
    localparam int         RESET_PULSE_CYC = 16;

    // one host i/o access as seen by the block
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_type;

endpackage : wdog_pkg

// ==== superio_watchdog_timer.sv ====
// watchdog timer of the super i/o: index/data configuration, count-down, reset request
// assumes io_req strobes are synchronous to clk and last one cycle per host access
//
// Functional notes
// [RULE_01] count down loaded value; zero requests reset; a loaded zero leaves the timer idle instead
// [RULE_02] software reloads before the timeout expires
// [RULE_03] two 87 writes to 2E unlock config
// [RULE_04] select logical device 08 via index 07
// [RULE_05] register 30 enables or disables watchdog
// [RULE_06] register F0 bit3 picks minutes, else seconds
// [RULE_07] register F1 loads timeout in units
// [RULE_08] index port picks register, data port accesses
`timescale 1ns/1ps

module superio_watchdog_timer #(
    parameter longint TICK_CYCLES = wdog_pkg::SECOND_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire wdog_pkg::io_req_type io_req,
    output logic [7:0]               rdata,
    output logic                     rdata_valid,
    output logic                     sys_reset_req,
    output logic                     system_watchdog_running
);
    import wdog_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input io_req_type r, input logic [7:0] port, input logic is_wr);
        hit = (is_wr ? r.wr : r.rd) && (r.addr == port);
    endfunction : hit

    logic       idx_wr;
    logic       dat_wr;
    logic       dat_rd;
    logic       wd_sel;

    // port strobes; a read of the index port is not decoded and returns zero
    assign idx_wr = hit(io_req, INDEX_PORT, 1'b1);
    assign dat_wr = hit(io_req, DATA_PORT, 1'b1);
    assign dat_rd = hit(io_req, DATA_PORT, 1'b0);

    // ------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LOCKED   = 3'b001,
        HALF_KEY = 3'b010,
        UNLOCKED = 3'b100
    } cfg_state_type;

    cfg_state_type cfg_q;

    // any index write other than the key between the two bytes restarts the sequence;
    // the lock byte closes it again so a stray program cannot reach the watchdog by accident
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= LOCKED;
        end else if (idx_wr) begin
            unique case (cfg_q)
                LOCKED:   cfg_q <= (io_req.wdata == UNLOCK_BYTE) ? HALF_KEY : LOCKED; // see [RULE_03]
                HALF_KEY: cfg_q <= (io_req.wdata == UNLOCK_BYTE) ? UNLOCKED : LOCKED; // see [RULE_03]
                UNLOCKED: cfg_q <= (io_req.wdata == LOCK_BYTE) ? LOCKED : UNLOCKED;
            endcase
        end
    end

    // configuration accesses count only once both key bytes arrived in a row
    logic cfg_open;
    assign cfg_open = (cfg_q == UNLOCKED); // see [RULE_03]

    // ------------------------------------------------------------
    // index and configuration registers
    // ------------------------------------------------------------
    logic [7:0] index_q;
    logic [7:0] ldev_q;
    logic [7:0] activate_q;
    logic [7:0] unit_q;
    logic [7:0] count_q;
    logic       load_pulse;

    // index latched only while unlocked; key bytes written while locked never become an index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            index_q <= RESET_BYTE;
        end else if (idx_wr && cfg_open) begin
            index_q <= io_req.wdata; // see [RULE_08]
        end
    end

    // the watchdog registers only answer while their logical device is selected
    assign wd_sel = cfg_open && (ldev_q == WDOG_LDEV); // see [RULE_04]

    // device registers answer only with the watchdog device selected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ldev_q     <= RESET_BYTE;
            activate_q <= RESET_BYTE;
            unit_q     <= RESET_BYTE;
            count_q    <= RESET_BYTE;
        end else if (dat_wr && cfg_open) begin
            if (index_q == IDX_LDEV_SELECT) begin
                ldev_q <= io_req.wdata; // see [RULE_04]
            end else if (wd_sel) begin
                unique case (index_q)
                    IDX_ACTIVATE:    activate_q <= io_req.wdata; // see [RULE_05]
                    IDX_TIME_UNIT:   unit_q     <= io_req.wdata; // see [RULE_06]
                    IDX_COUNT_VALUE: count_q    <= io_req.wdata; // see [RULE_07]
                    default:         ;
                endcase
            end
        end
    end

    // a count write is also the kick: software keeps the timer alive by repeating it
    assign load_pulse = dat_wr && wd_sel && (index_q == IDX_COUNT_VALUE); // see [RULE_02]

    // read path, one cycle after the strobe; unmapped indexes read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata       <= RESET_BYTE;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= dat_rd;
            rdata       <= RESET_BYTE;
            if (dat_rd && cfg_open) begin
                if (index_q == IDX_LDEV_SELECT) begin
                    rdata <= ldev_q; // see [RULE_08]
                end else if (wd_sel) begin
                    unique case (index_q)
                        IDX_ACTIVATE:    rdata <= activate_q;
                        IDX_TIME_UNIT:   rdata <= unit_q;
                        IDX_COUNT_VALUE: rdata <= count_q;
                        default:         rdata <= RESET_BYTE;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // time base: one-second enable, one-minute enable
    // ------------------------------------------------------------
    localparam int PW = $clog2(TICK_CYCLES + 1);
    logic [PW-1:0] pre_q;
    logic [5:0]    sec_q;
    logic          sec_tick;
    logic          min_tick;
    logic          enabled;

    // one-cycle enables from the divider; the minute enable rides on the second enable
    // so a minute is exactly SECONDS_PER_MIN seconds and no second divider is needed
    assign enabled  = activate_q[ACTIVATE_BIT]; // see [RULE_05]
    assign sec_tick = enabled && (pre_q == PW'(TICK_CYCLES - 1));
    assign min_tick = sec_tick && (sec_q == SECONDS_PER_MIN - 6'h01);

    // prescaler restarts on every reload so a full unit always elapses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
            sec_q <= '0;
        end else if (!enabled || load_pulse) begin
            pre_q <= '0;
            sec_q <= '0;
        end else if (sec_tick) begin
            pre_q <= '0;
            sec_q <= min_tick ? 6'h00 : sec_q + 6'h01;
        end else begin
            pre_q <= pre_q + PW'(1);
        end
    end

    // ------------------------------------------------------------
    // countdown and reset request
    // ------------------------------------------------------------
    logic [7:0] remain_q;
    logic       unit_tick;
    logic [4:0] pulse_q;

    // the unit bit only picks which enable decrements the count; other bits are stored, unused
    assign unit_tick = unit_q[MINUTE_BIT] ? min_tick : sec_tick; // see [RULE_06]

    // a count of zero leaves the timer idle rather than firing at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain_q <= RESET_BYTE;
        end else if (load_pulse) begin
            remain_q <= io_req.wdata; // see [RULE_07] and [RULE_02]
        end else if (!enabled) begin
            remain_q <= remain_q;
        end else if (unit_tick && remain_q != RESET_BYTE) begin
            remain_q <= remain_q - 8'h01; // see [RULE_01]
        end
    end

    // reset request held a fixed number of cycles so the reset logic surely sees it;
    // the count stays at zero afterwards, only a reload rearms the timer; a system reset also loads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q       <= '0;
            sys_reset_req <= 1'b0;
        end else begin
            if (enabled && unit_tick && remain_q == 8'h01) begin
                pulse_q <= 5'(RESET_PULSE_CYC); // see [RULE_01]
            end else if (pulse_q != '0) begin
                pulse_q <= pulse_q - 5'h01;
            end
            sys_reset_req <= (pulse_q != '0);
        end
    end

    // running flag for status; it drops with the request, since the count is then zero,
    // and stays low while disabled so a frozen count does not look alive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            system_watchdog_running <= 1'b0;
        end else begin
            system_watchdog_running <= enabled && (remain_q != RESET_BYTE);
        end
    end

endmodule : superio_watchdog_timer

// ==== wdog_asserts.sv ====
// checker for the watchdog ports: read answers, reset pulse, start cause
// assumes it is bound to superio_watchdog_timer
`timescale 1ns/1ps
module wdog_asserts (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire wdog_pkg::io_req_type io_req,
    input wire logic [7:0]           rdata,
    input wire logic                 rdata_valid,
    input wire logic                 sys_reset_req,
    input wire logic                 system_watchdog_running
);
    import wdog_pkg::*;
    // ------------------------------------------------------------
    // relations, all on the one clock
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_drd; io_req.rd && io_req.addr == DATA_PORT; endsequence
    sequence s_hold; sys_reset_req [*8] ##1 sys_reset_req [*8] ##1 !sys_reset_req; endsequence
    property p_rd; s_drd |=> rdata_valid; endproperty
    a_rd: assert property (p_rd) else $error("read of data port unanswered");
    property p_nord; !io_req.rd |=> !rdata_valid; endproperty
    a_nord: assert property (p_nord) else $error("answer without read");
    property p_zero; !rdata_valid |-> rdata == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("read byte not zero when idle");
    property p_hold; $rose(sys_reset_req) |-> s_hold; endproperty
    a_hold: assert property (p_hold) else $error("reset request length wrong");
    property p_fire; $rose(sys_reset_req) |-> !system_watchdog_running; endproperty
    a_fire: assert property (p_fire) else $error("reset while still running");
    property p_cause; $rose(sys_reset_req) |-> $past(system_watchdog_running, 2); endproperty
    a_cause: assert property (p_cause) else $error("reset without countdown");
    // only a data write (enable or count) may start the countdown
    property p_start;
        $rose(system_watchdog_running) |-> $past(io_req.wr && io_req.addr == DATA_PORT, 1)
            || $past(io_req.wr && io_req.addr == DATA_PORT, 2);
    endproperty
    a_start: assert property (p_start) else $error("started without data write");
endmodule : wdog_asserts

// ==== wdog_host.sv ====
// host model: i/o writes and reads on the index and data ports
// assumes strobes launched at falling edges, one cycle long
`timescale 1ns/1ps
module wdog_host (
    input  wire logic                 clk,
    input  wire logic [7:0]           rdata,
    input  wire logic                 rdata_valid,
    output wdog_pkg::io_req_type      io_req
);
    import wdog_pkg::*;
    initial io_req = '0;
    // released lines show the inverse, so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_req = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        io_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic getr(input logic [7:0] idx, output logic [7:0] d, output logic v);
        wr(INDEX_PORT, idx);
        @(negedge clk);
        io_req = '{1'b0, 1'b1, DATA_PORT, 8'h00};
        @(negedge clk);
        d = rdata;
        v = rdata_valid;
        io_req = '{1'b0, 1'b0, ~DATA_PORT, 8'hFF};
    endtask : getr
    task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
        wr(INDEX_PORT, idx);
        wr(DATA_PORT, d);
    endtask : cfg
    task automatic unlock;
        wr(INDEX_PORT, UNLOCK_BYTE);
        wr(INDEX_PORT, UNLOCK_BYTE);
    endtask : unlock
endmodule : wdog_host

// ==== testbench.sv ====
// self-checking bench for the watchdog with a shortened tick
// assumes wdog_host drives all i/o cycles
`timescale 1ns/1ps
module testbench;
    import wdog_pkg::*;
    localparam int TICK = 10;
    logic       clk, rst_n, rdata_valid, sys_reset_req, running, v;
    logic [7:0] rdata, d, r8;
    io_req_type io_req;
    int         fails, total_checks, seed, c;
    superio_watchdog_timer #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst_n(rst_n), .io_req(io_req),
        .rdata(rdata), .rdata_valid(rdata_valid), .sys_reset_req(sys_reset_req),
        .system_watchdog_running(running));
    wdog_host host (.clk(clk), .rdata(rdata), .rdata_valid(rdata_valid), .io_req(io_req));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // one compare for flags, one for bytes; the case inequality keeps an unknown from passing
    task automatic chkb(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t flag %b not %b", $time, g, e);
        end
    endtask : chkb
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t byte %h not %h", $time, g, e);
        end
    endtask : chk8
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
        host.getr(idx, d, v);
        chkb(v, 1'b1);
        chk8(d, e);
    endtask : rdchk
    // cycles from a count write to the request: count times the length of one unit
    function automatic int exp_cycles(input logic [7:0] u, input logic [7:0] n);
        exp_cycles = int'(n) * (u[MINUTE_BIT] ? int'(SECONDS_PER_MIN) : 1) * TICK;
    endfunction : exp_cycles
    // load count, time the request, then its length; a hang ends the run
    task automatic fire(input logic [7:0] u, input logic [7:0] n);
        int e;
        e = exp_cycles(u, n);
        host.cfg(IDX_TIME_UNIT, u);
        host.cfg(IDX_COUNT_VALUE, n);
        c = 0;
        while (sys_reset_req !== 1'b1 && c < 3000) begin
            @(negedge clk);
            c++;
        end
        chkb(c >= e - 1 && c <= e + 3, 1'b1);
        if (c == 3000) begin
            fails++;
            give_verdict();
        end
        c = 0;
        while (sys_reset_req === 1'b1 && c < 100) begin
            @(negedge clk);
            c++;
        end
        chkb(c == RESET_PULSE_CYC, 1'b1);
        chkb(running, 1'b0);
    endtask : fire
    // free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        seed = 91;
        fails = 0;
        total_checks = 0;
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        chkb(sys_reset_req | running | rdata_valid, 1'b0);
        rst_n = 1'b1;
        // a foreign byte between key bytes restarts the unlock
        host.wr(INDEX_PORT, UNLOCK_BYTE);
        host.cfg(IDX_LDEV_SELECT, WDOG_LDEV);
        host.wr(INDEX_PORT, UNLOCK_BYTE);
        rdchk(IDX_LDEV_SELECT, 8'h00);
        host.unlock();
        r8 = 8'($random(seed));
        if (r8 == WDOG_LDEV) begin
            r8 = 8'h09;
        end
        host.cfg(IDX_LDEV_SELECT, r8);
        host.cfg(IDX_ACTIVATE, 8'h01);
        rdchk(IDX_LDEV_SELECT, r8);
        rdchk(IDX_ACTIVATE, 8'h00);
        host.cfg(IDX_LDEV_SELECT, WDOG_LDEV);
        host.cfg(IDX_ACTIVATE, 8'h01);
        rdchk(IDX_ACTIVATE, 8'h01);
        r8 = 8'($random(seed));
        host.cfg(IDX_TIME_UNIT, r8);
        rdchk(IDX_TIME_UNIT, r8);
        host.cfg(8'hE5, r8);
        rdchk(8'hE5, 8'h00);
        chkb(running, 1'b0);
        fire(8'h00, 8'h0A);
        fire(8'h08, 8'h01);
        // timely kicks keep the request away
        host.cfg(IDX_TIME_UNIT, 8'h00);
        repeat (6) begin
            c = {$random(seed)} % 30;
            repeat (c) @(negedge clk);
            host.cfg(IDX_COUNT_VALUE, 8'h05);
            chkb(sys_reset_req, 1'b0);
        end
        rdchk(IDX_COUNT_VALUE, 8'h05);
        host.cfg(IDX_ACTIVATE, 8'h00);
        repeat (100) @(negedge clk);
        chkb(running | sys_reset_req, 1'b0);
        host.cfg(IDX_ACTIVATE, 8'h01);
        repeat (3) @(negedge clk);
        chkb(running, 1'b1);
        // a zero count leaves the timer idle instead of firing
        host.cfg(IDX_COUNT_VALUE, 8'h00);
        repeat (3) @(negedge clk);
        chkb(running | sys_reset_req, 1'b0);
        host.wr(INDEX_PORT, LOCK_BYTE);
        rdchk(IDX_ACTIVATE, 8'h00);
        give_verdict();
    end
endmodule : testbench
bind superio_watchdog_timer wdog_asserts chk (.clk(clk), .rst_n(rst_n), .io_req(io_req), .rdata(rdata),
    .rdata_valid(rdata_valid), .sys_reset_req(sys_reset_req), .system_watchdog_running(system_watchdog_running));
